// ### inc/efsp_pkg.sv
// shared constants for the encoder feedback select and phasing block
// Contract
// - resolution setting spans 2^12..2^20 counts per rev; feedback scaled to it
// - position kept as signed 32-bit word, wraps at +/-2^31
// - source select 00 resolver, 01 primary encoder, 10 auxiliary encoder
// - primary type codes 0,1,2,3,7,8,10 select decoding; others unusable
// - primary pulses per rev default 1024, plain or exponential format
// - auxiliary pulses per rev default 1024, own format bit
// - negative pulses per rev reverses counting direction
// - supply select 00 5 V, 01 8 V, 10 12 V
// - supply choice applied only at start-up from saved value
// - primary encoder lines pass a glitch filter with 3-bit code
// - auxiliary encoder lines pass their own glitch filter
// - code 0 needs 642.5 ns, each step adds 500 ns
// - phasing counts as not done after every power-up
// - each phasing command restarts the simulated encoder reference and zero
// - phasing command bit starts type 1 phasing, reads back 0
// - motor moved twice, last move 90 electrical degrees, sign checked
// - result codes 0 ok, 2 enable, 3 sign, 4 poles/pulses, 5 not ready
// - outcome flag set on success; drive ready never without it (the code gives drive ready without it when the resolver source is selected)
package efsp_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FBCFG = 8'h04;
    localparam logic [7:0] ADDR_TYPE = 8'h08;
    localparam logic [7:0] ADDR_PPR = 8'h0c;
    localparam logic [7:0] ADDR_RES = 8'h10;
    localparam logic [7:0] ADDR_POS = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;
    // field positions
    localparam int CTRL_CMD_BIT = 2;
    localparam int FB_PEXP_BIT = 1;
    localparam int FB_AEXP_BIT = 2;
    localparam int FB_SUP_LSB = 6;
    localparam int FB_PFILT_LSB = 8;
    localparam int FB_AFILT_LSB = 11;
    localparam int TYPE_AUX_LSB = 8;
    localparam int PPR_AUX_LSB = 16;
    localparam int RES_POLE_LSB = 8;
    // reset values
    localparam logic [15:0] PPR_RESET = 16'h0400;
    localparam logic [3:0] TYPE_RESET = 4'h3;
    localparam logic [4:0] RES_MIN = 5'h0c;
    localparam logic [4:0] RES_MAX = 5'h14;
    localparam logic [4:0] RES_RESET = 5'h10;
    localparam logic [7:0] POLE_RESET = 8'h04;
    localparam logic [4:0] EXP_MAX = 5'h12;
    localparam logic [15:0] PLAIN_MAX = 16'h7fff;
    // source and supply codes
    localparam logic [1:0] SRC_RESOLVER = 2'h0;
    localparam logic [1:0] SRC_PRIMARY = 2'h1;
    localparam logic [1:0] SRC_AUX = 2'h2;
    localparam logic [1:0] SUP_5V = 2'h0;
    localparam logic [1:0] SUP_12V = 2'h2;
    // encoder type codes
    localparam logic [3:0] TY_SC_ABS = 4'h0;
    localparam logic [3:0] TY_SC = 4'h1;
    localparam logic [3:0] TY_REDWIRE = 4'h2;
    localparam logic [3:0] TY_INCR = 4'h3;
    localparam logic [3:0] TY_SC_LINK2 = 4'h7;
    localparam logic [3:0] TY_SC_POLE = 4'h8;
    localparam logic [3:0] TY_INCR_HALL = 4'ha;
    // phasing result codes
    localparam logic [15:0] RC_OK = 16'h0000;
    localparam logic [15:0] RC_NEVER = 16'h0001;
    localparam logic [15:0] RC_ENABLE = 16'h0002;
    localparam logic [15:0] RC_SIGN = 16'h0003;
    localparam logic [15:0] RC_POLES = 16'h0004;
    localparam logic [15:0] RC_NOTRDY = 16'h0005;
    localparam logic [8:0] ANGLE_FIRST = 9'h000;
    localparam logic [8:0] ANGLE_FINAL = 9'h05a;
    // timing
    localparam int CLK_PS = 10000;
    localparam int FILT_BASE_PS = 642500;
    localparam int FILT_STEP_PS = 500000;
    localparam int FILT_BASE_CYC = (FILT_BASE_PS + CLK_PS - 1) / CLK_PS;
    localparam int FILT_STEP_CYC = FILT_STEP_PS / CLK_PS;
    localparam logic [8:0] FILT_BASE_W = 9'(FILT_BASE_CYC);
    localparam logic [8:0] FILT_STEP_W = 9'(FILT_STEP_CYC);
    localparam int MOVE_TIME_US = 100000;
    localparam int MOVE_CYC = MOVE_TIME_US * (1000000 / CLK_PS);
    typedef enum logic [1:0] {PH_IDLE, PH_MOVE1, PH_MOVE2} efsp_phase_t;
endpackage

// ### src/efsp_top.sv
// encoder feedback selection, filtering, position scaling and phasing
//
// Our own choices: the register offsets and the APB interface to the registers.
module efsp_top #(
    parameter int MOVE_CYCLES = efsp_pkg::MOVE_CYC,
    parameter logic [15:0] RESOLVER_LINES = 16'h0400
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic resolverA,
    input wire logic resolverB,
    input wire logic primaryA,
    input wire logic primaryB,
    input wire logic auxA,
    input wire logic auxB,
    input wire logic softwareEnable,
    input wire logic hardwareEnable,
    input wire logic [7:0] alarmCode,
    input wire logic inrushClosed,
    input wire logic [1:0] savedSupplySel,
    output logic [1:0] encSupplySel,
    output logic phaseMoveReq,
    output logic [8:0] phaseAngleDeg,
    output logic simRefReset,
    output logic phasingOk,
    output logic driveReady,
    output logic [31:0] position
);
    ////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [1:0] posSrc_q;
    logic cmd_q;
    logic [31:0] fbCfg_q;
    logic [3:0] pType_q, aType_q;
    logic [15:0] pPpr_q, aPpr_q;
    logic [4:0] res_q;
    logic [7:0] poles_q;
    logic [15:0] result_q;
    efsp_pkg::efsp_phase_t phase_q;
    logic [31:0] moveCnt_q;
    logic signed [23:0] phaseCnt_q;
    logic signed [31:0] pos_q;
    logic signed [47:0] resid_q;
    logic [5:0] prevAB_q;
    logic [3:0] filt;
    logic started_q;
    logic rdy_q, ok_q, move_q, simRst_q, err_q;
    logic [1:0] sup_q;
    logic [8:0] angle_q;
    logic [31:0] rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // glitch filters on the encoder lines
    wire [3:0] rawLines = {auxB, auxA, primaryB, primaryA};
    wire [2:0] pFilt = fbCfg_q[efsp_pkg::FB_PFILT_LSB +: 3];
    wire [2:0] aFilt = fbCfg_q[efsp_pkg::FB_AFILT_LSB +: 3];
    for (genvar i = 0; i < 4; i++) begin : g_filt
        logic [8:0] cnt_q;
        logic out_q;
        wire [2:0] code = (i < 2) ? pFilt : aFilt;
        wire [8:0] thr = efsp_pkg::FILT_BASE_W
            + 9'(code) * efsp_pkg::FILT_STEP_W;
        // level passes only after thr stable samples
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                cnt_q <= 9'h000;
                out_q <= 1'b0;
            end else if (ce) begin
                if (rawLines[i] == out_q) begin
                    cnt_q <= 9'h000;
                end else if (cnt_q + 9'h001 >= thr) begin
                    out_q <= rawLines[i];
                    cnt_q <= 9'h000;
                end else begin
                    cnt_q <= cnt_q + 9'h001;
                end
            end
        end
        assign filt[i] = out_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // pulses-per-rev decoding: magnitude and reversal flag
    function automatic logic [19:0] pprMag(input logic [15:0] v,
                                           input logic expFmt);
        logic [4:0] n;
        logic [15:0] m;
        n = (v[4:0] > efsp_pkg::EXP_MAX) ? efsp_pkg::EXP_MAX : v[4:0];
        m = v[15] ? 16'(-v) : v;
        if (m > efsp_pkg::PLAIN_MAX) begin
            m = efsp_pkg::PLAIN_MAX;
        end
        pprMag = expFmt ? (20'h00001 << n) : {4'h0, m};
    endfunction

    wire pExp = fbCfg_q[efsp_pkg::FB_PEXP_BIT];
    wire aExp = fbCfg_q[efsp_pkg::FB_AEXP_BIT];
    logic [19:0] mag;
    logic neg, typeOk, qa, qb, pa, pb;
    // pick source pins, scale and polarity
    always_comb begin
        mag = 20'h00000;
        neg = 1'b0;
        typeOk = 1'b0;
        {qb, qa} = 2'b00;
        {pb, pa} = 2'b00;
        unique case (posSrc_q)
            efsp_pkg::SRC_RESOLVER: begin
                mag = {4'h0, RESOLVER_LINES};
                typeOk = 1'b1;
                {qb, qa} = {resolverB, resolverA};
                {pb, pa} = prevAB_q[1:0];
            end
            efsp_pkg::SRC_PRIMARY: begin
                mag = pprMag(pPpr_q, pExp);
                neg = pPpr_q[15];
                typeOk = pType_q inside {efsp_pkg::TY_SC_ABS, efsp_pkg::TY_SC,
                    efsp_pkg::TY_REDWIRE, efsp_pkg::TY_INCR,
                    efsp_pkg::TY_SC_LINK2, efsp_pkg::TY_SC_POLE,
                    efsp_pkg::TY_INCR_HALL};
                {qb, qa} = filt[1:0];
                {pb, pa} = prevAB_q[3:2];
            end
            efsp_pkg::SRC_AUX: begin
                mag = pprMag(aPpr_q, aExp);
                neg = aPpr_q[15];
                typeOk = (aType_q == efsp_pkg::TY_INCR);
                {qb, qa} = filt[3:2];
                {pb, pa} = prevAB_q[5:4];
            end
            default: begin
                typeOk = 1'b0;
            end
        endcase
    end

    // one quadrature edge per step, direction flipped for negative count
    wire [47:0] den = {26'h0, mag, 2'b00};
    wire stepEv = typeOk && (den != 48'h0) && ((qa ^ pa) ^ (qb ^ pb));
    wire stepUp = (qa ^ pb) ^ neg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prevAB_q <= 6'h00;
        end else if (ce) begin
            prevAB_q <= {filt[3:2], filt[1:0], resolverB, resolverA};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // scale edges to the resolution: residue of 2^res per edge, paid out
    // in power-of-two chunks so a big ratio settles in a few cycles
    logic [47:0] rMag;
    logic [5:0] sh;
    logic fits;
    always_comb begin
        rMag = resid_q[47] ? 48'(-resid_q) : 48'(resid_q);
        sh = 6'h00;
        fits = (den != 48'h0) && (den <= rMag);
        for (int s = 1; s < 24; s++) begin
            if ((den << s) <= rMag) begin
                sh = 6'(s);
            end
        end
    end

    wire signed [47:0] stepW = 48'sh1 <<< res_q;
    wire signed [47:0] addW = stepEv ? (stepUp ? stepW : -stepW) : 48'sh0;
    wire signed [47:0] subW = fits ? (resid_q[47] ? -48'(den << sh)
                                                  : 48'(den << sh)) : 48'sh0;
    wire signed [31:0] posInc = fits ? (resid_q[47] ? -(32'sh1 <<< sh)
                                                    : (32'sh1 <<< sh)) : 32'sh0;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resid_q <= 48'sh0;
            pos_q <= 32'sh0;
        end else if (ce) begin
            resid_q <= resid_q + addW - subW;
            pos_q <= pos_q + posInc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // encoder supply: take saved choice once after reset release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            started_q <= 1'b0;
            sup_q <= efsp_pkg::SUP_5V;
        end else if (ce && !started_q) begin
            started_q <= 1'b1;
            sup_q <= (savedSupplySel > efsp_pkg::SUP_12V)
                ? efsp_pkg::SUP_5V : savedSupplySel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // type 1 phasing sequence
    wire enBad = softwareEnable || !hardwareEnable;
    wire notRdy = (alarmCode != 8'h00) || !inrushClosed;
    wire polesBad = (poles_q == 8'h00) || poles_q[0] || (den == 48'h0);
    wire signed [47:0] cntScaled = 48'(phaseCnt_q) * 48'(poles_q) * 48'sd8;
    wire rangeBad = (cntScaled < 48'(den * 48'd3))
        || (cntScaled > 48'(den * 48'd5));
    wire timeUp = (moveCnt_q >= 32'(MOVE_CYCLES - 1));
    wire wrEn = psel && penable && pready && pwrite;
    wire cmdWr = wrEn && (paddr == efsp_pkg::ADDR_CTRL)
        && pwdata[efsp_pkg::CTRL_CMD_BIT];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= efsp_pkg::PH_IDLE;
            result_q <= efsp_pkg::RC_NEVER;
            ok_q <= 1'b0;
            move_q <= 1'b0;
            angle_q <= efsp_pkg::ANGLE_FIRST;
            simRst_q <= 1'b0;
            moveCnt_q <= 32'h0;
            phaseCnt_q <= 24'sh0;
        end else if (ce) begin
            simRst_q <= 1'b0;
            moveCnt_q <= moveCnt_q + 32'h1;
            unique case (phase_q)
                efsp_pkg::PH_IDLE: begin
                    if (cmd_q) begin
                        simRst_q <= 1'b1;
                        ok_q <= 1'b0;
                        if (enBad) begin
                            result_q <= efsp_pkg::RC_ENABLE;
                        end else if (notRdy) begin
                            result_q <= efsp_pkg::RC_NOTRDY;
                        end else if (polesBad) begin
                            result_q <= efsp_pkg::RC_POLES;
                        end else begin
                            phase_q <= efsp_pkg::PH_MOVE1;
                            move_q <= 1'b1;
                            angle_q <= efsp_pkg::ANGLE_FIRST;
                            moveCnt_q <= 32'h0;
                        end
                    end
                end
                efsp_pkg::PH_MOVE1, efsp_pkg::PH_MOVE2: begin
                    if (phase_q == efsp_pkg::PH_MOVE2 && stepEv) begin
                        phaseCnt_q <= stepUp ? phaseCnt_q + 24'sh1
                                             : phaseCnt_q - 24'sh1;
                    end
                    if (enBad || notRdy) begin
                        result_q <= enBad ? efsp_pkg::RC_ENABLE
                                          : efsp_pkg::RC_NOTRDY;
                        phase_q <= efsp_pkg::PH_IDLE;
                        move_q <= 1'b0;
                    end else if (timeUp && phase_q == efsp_pkg::PH_MOVE1) begin
                        phase_q <= efsp_pkg::PH_MOVE2;
                        angle_q <= efsp_pkg::ANGLE_FINAL;
                        moveCnt_q <= 32'h0;
                        phaseCnt_q <= 24'sh0;
                    end else if (timeUp) begin
                        phase_q <= efsp_pkg::PH_IDLE;
                        move_q <= 1'b0;
                        if (phaseCnt_q <= 24'sh0) begin
                            result_q <= efsp_pkg::RC_SIGN;
                        end else if (rangeBad) begin
                            result_q <= efsp_pkg::RC_POLES;
                        end else begin
                            result_q <= efsp_pkg::RC_OK;
                            ok_q <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // drive ready needs the phasing outcome unless a resolver is in use
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdy_q <= 1'b0;
        end else if (ce) begin
            rdy_q <= (ok_q || posSrc_q == efsp_pkg::SRC_RESOLVER)
                && !notRdy && hardwareEnable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave: no wait states, answer in the first access cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            posSrc_q <= efsp_pkg::SRC_PRIMARY;
            cmd_q <= 1'b0;
            fbCfg_q <= 32'h0;
            pType_q <= efsp_pkg::TYPE_RESET;
            aType_q <= efsp_pkg::TYPE_RESET;
            pPpr_q <= efsp_pkg::PPR_RESET;
            aPpr_q <= efsp_pkg::PPR_RESET;
            res_q <= efsp_pkg::RES_RESET;
            poles_q <= efsp_pkg::POLE_RESET;
        end else if (ce) begin
            if (phase_q == efsp_pkg::PH_IDLE && cmd_q) begin
                cmd_q <= 1'b0;
            end
            if (wrEn) begin
                unique case (paddr)
                    efsp_pkg::ADDR_CTRL: begin
                        posSrc_q <= pwdata[1:0];
                        if (cmdWr) begin
                            cmd_q <= 1'b1;
                        end
                    end
                    efsp_pkg::ADDR_FBCFG: fbCfg_q <= pwdata;
                    efsp_pkg::ADDR_TYPE: begin
                        pType_q <= pwdata[3:0];
                        aType_q <= pwdata[efsp_pkg::TYPE_AUX_LSB +: 4];
                    end
                    efsp_pkg::ADDR_PPR: begin
                        pPpr_q <= pwdata[15:0];
                        aPpr_q <= pwdata[efsp_pkg::PPR_AUX_LSB +: 16];
                    end
                    efsp_pkg::ADDR_RES: begin
                        res_q <= (pwdata[4:0] < efsp_pkg::RES_MIN)
                            ? efsp_pkg::RES_MIN
                            : (pwdata[4:0] > efsp_pkg::RES_MAX)
                            ? efsp_pkg::RES_MAX : pwdata[4:0];
                        poles_q <= pwdata[efsp_pkg::RES_POLE_LSB +: 8];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // read data and error, captured in the setup cycle
    logic [31:0] rd;
    logic bad;
    always_comb begin
        rd = 32'h0;
        bad = 1'b0;
        unique case (paddr)
            efsp_pkg::ADDR_CTRL: rd = {29'h0, 1'b0, posSrc_q};
            efsp_pkg::ADDR_FBCFG: rd = fbCfg_q;
            efsp_pkg::ADDR_TYPE: rd = {20'h0, aType_q, 4'h0, pType_q};
            efsp_pkg::ADDR_PPR: rd = {aPpr_q, pPpr_q};
            efsp_pkg::ADDR_RES: rd = {16'h0, poles_q, 3'h0, res_q};
            efsp_pkg::ADDR_POS: begin
                rd = pos_q;
                bad = pwrite;
            end
            efsp_pkg::ADDR_STAT: begin
                rd = {11'h0, phase_q != efsp_pkg::PH_IDLE, sup_q, rdy_q,
                      ok_q, result_q};
                bad = pwrite;
            end
            default: bad = 1'b1;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 32'h0;
            pready <= 1'b0;
            err_q <= 1'b0;
        end else if (ce) begin
            pready <= psel && !penable;
            rdata_q <= (psel && !penable && !pwrite) ? rd : 32'h0;
            err_q <= psel && !penable && bad;
        end
    end

    // outputs straight from flops
    assign prdata = rdata_q;
    assign pslverr = err_q;
    assign encSupplySel = sup_q;
    assign phaseMoveReq = move_q;
    assign phaseAngleDeg = angle_q;
    assign simRefReset = simRst_q;
    assign phasingOk = ok_q;
    assign driveReady = rdy_q;
    assign position = pos_q;
endmodule

// ### bench/efsp_checker.sv
// port assertions for the feedback block
module efsp_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hardwareEnable,
    input wire logic [7:0] alarmCode,
    input wire logic inrushClosed,
    input wire logic [1:0] encSupplySel,
    input wire logic phaseMoveReq,
    input wire logic [8:0] phaseAngleDeg,
    input wire logic simRefReset,
    input wire logic phasingOk,
    input wire logic driveReady
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////
    // register bus answer
    bus_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer");
    one_answer_a: assert property (pready |=> !pready)
        else $error("long answer");
    err_answer_a: assert property (pslverr |-> pready)
        else $error("lone error");
    ////////////////////////////////////////////////////////////////////////
    // phasing
    ref_pulse_a: assert property (simRefReset |=> !simRefReset)
        else $error("long ref reset");
    first_angle_a: assert property ($rose(phaseMoveReq) |->
        phaseAngleDeg == efsp_pkg::ANGLE_FIRST)
        else $error("bad first angle");
    final_angle_a: assert property (phaseMoveReq &&
        $past(phaseMoveReq) && $changed(phaseAngleDeg)
        |-> phaseAngleDeg == efsp_pkg::ANGLE_FINAL)
        else $error("bad final angle");
    ok_after_move_a: assert property ($rose(phasingOk) |->
        $past(phaseMoveReq) && $past(phaseAngleDeg) == efsp_pkg::ANGLE_FINAL)
        else $error("outcome too early");
    ready_cause_a: assert property (driveReady |->
        $past(hardwareEnable) && $past(alarmCode) == 8'h00
        && $past(inrushClosed))
        else $error("ready without cause");
    power_up_a: assert property ($rose(reset_n) |-> !phasingOk)
        else $error("outcome after reset");
    ////////////////////////////////////////////////////////////////////////
    // encoder supply
    supply_latch_a: assert property ($changed(encSupplySel) |->
        !$past(reset_n, 2))
        else $error("supply changed late");
    supply_code_a: assert property (encSupplySel != 2'h3)
        else $error("bad supply code");
    cover property ($rose(phasingOk));
    cover property ($rose(phaseMoveReq));
    cover property (pslverr);
    cover property (driveReady);
endmodule

bind efsp_top efsp_checker u_efsp_checker (.*);

// ### bench/efsp_encoder_model.sv
// quadrature encoder model on the motor shaft
module efsp_encoder_model #(
    parameter int STEP_CYC = 70
) (
    input wire logic clk,
    input wire logic run,
    input wire logic reverse,
    input wire logic phaseMoveReq,
    input wire logic [8:0] phaseAngleDeg,
    output logic lineA,
    output logic lineB,
    output int steps
);
    timeunit 1ns;
    timeprecision 1ps;
    int timer = 0;
    int stepCount = 0;
    logic [1:0] phase = 2'h0;
    // turns on a jog or in the final phasing move; a leads going forward
    wire moving = run
        || (phaseMoveReq && phaseAngleDeg == efsp_pkg::ANGLE_FINAL);
    // one quadrature step per step period
    always_ff @(posedge clk) begin
        timer <= (moving && timer < STEP_CYC - 1) ? timer + 1 : 0;
        if (moving && timer == STEP_CYC - 1) begin
            phase <= phase + (reverse ? 2'h3 : 2'h1);
            stepCount <= stepCount + 1;
        end
    end
    assign lineA = phase[1] ^ phase[0];
    assign lineB = phase[1];
    assign steps = stepCount;
endmodule

// ### bench/testbench.sv
// self-checking bench for the feedback block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, position, rd;
    logic pready, pslverr, err, encA, encB, phaseMoveReq;
    logic softwareEnable = 1'b0, hardwareEnable = 1'b1, inrushClosed = 1'b1;
    logic [7:0] alarmCode = 8'h00;
    logic [1:0] savedSupplySel = 2'h2, encSupplySel;
    logic simRefReset, phasingOk, driveReady, run = 1'b0, reverse = 1'b0;
    logic [8:0] phaseAngleDeg;
    int steps, fails = 0, checks = 0, refs = 0;
    always #5 clk = ~clk;
    efsp_top #(.MOVE_CYCLES(600)) u_efsp_top (.clk(clk), .reset_n(reset_n),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .resolverA(1'b0), .resolverB(1'b0),
        .primaryA(encA), .primaryB(encB), .auxA(encA), .auxB(encB),
        .softwareEnable(softwareEnable), .hardwareEnable(hardwareEnable),
        .alarmCode(alarmCode), .inrushClosed(inrushClosed),
        .savedSupplySel(savedSupplySel), .encSupplySel(encSupplySel),
        .phaseMoveReq(phaseMoveReq), .phaseAngleDeg(phaseAngleDeg),
        .simRefReset(simRefReset), .phasingOk(phasingOk),
        .driveReady(driveReady), .position(position));
    efsp_encoder_model u_efsp_encoder_model (.clk(clk), .run(run),
        .reverse(reverse), .phaseMoveReq(phaseMoveReq),
        .phaseAngleDeg(phaseAngleDeg), .lineA(encA), .lineB(encB),
        .steps(steps));
    // count reference reset pulses
    always @(posedge clk) begin
        if (simRefReset === 1'b1) refs++;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // apb transfer, held until pready
    task automatic apb(logic wr, logic [7:0] addr, logic [31:0] data);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        for (int n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
        if (pready !== 1'b1) begin
            fails++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(string nm, logic [7:0] a, logic [31:0] e, m);
        apb(1'b0, a, 32'h0);
        check(nm, e & m, rd & m);
    endtask
    task automatic do_reset(logic [1:0] sup);
        reset_n <= 1'b0;
        savedSupplySel <= sup;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        savedSupplySel <= ~sup;
    endtask
    // turn n steps, settle, check position
    task automatic jog(int n, logic [31:0] expPos);
        int t;
        t = steps + n;
        run <= 1'b1;
        for (int i = 0; i < n * 80 && steps < t; i++) @(posedge clk);
        if (steps < t) fails++;
        run <= 1'b0;
        repeat (500) @(posedge clk);
        rdc("position", efsp_pkg::ADDR_POS, expPos, '1);
    endtask
    task automatic phase(logic [15:0] code);
        apb(1'b1, efsp_pkg::ADDR_CTRL, 32'h5);
        repeat (3) @(posedge clk);
        rd = 32'h00100000;
        for (int n = 0; n < 500 && rd[20] !== 1'b0; n++)
            apb(1'b0, efsp_pkg::ADDR_STAT, 32'h0);
        if (rd[20] !== 1'b0) fails++;
        check("result", {16'h0, code}, {16'h0, rd[15:0]});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        stop_test();
    end
    initial begin
        do_reset(2'h2);
        rdc("ppr", efsp_pkg::ADDR_PPR, 32'h04000400, '1);
        rdc("stat", efsp_pkg::ADDR_STAT, 32'h00080001, 32'h001fffff);
        check("supply", 32'h2, 32'(encSupplySel));
        apb(1'b1, efsp_pkg::ADDR_POS, 32'h1);
        check("ro error", 32'h1, 32'(err));
        apb(1'b0, 8'h1c, 32'h0);
        check("unmapped", 32'h1, 32'(err));
        apb(1'b1, efsp_pkg::ADDR_CTRL, 32'h1);
        apb(1'b1, efsp_pkg::ADDR_FBCFG, 32'h0);
        jog(8, 32'd128);
        apb(1'b1, efsp_pkg::ADDR_RES, 32'h40c);
        jog(4, 32'd132);
        apb(1'b1, efsp_pkg::ADDR_RES, 32'h40b);
        jog(4, 32'd136);
        apb(1'b1, efsp_pkg::ADDR_PPR, 32'h0400fc00);
        jog(4, 32'd132);
        apb(1'b1, efsp_pkg::ADDR_FBCFG, 32'h2);
        apb(1'b1, efsp_pkg::ADDR_PPR, 32'h0400000a);
        jog(4, 32'd136);
        apb(1'b1, efsp_pkg::ADDR_CTRL, 32'h2);
        jog(4, 32'd140);
        apb(1'b1, efsp_pkg::ADDR_FBCFG, 32'h3800);
        jog(4, 32'd140);
        apb(1'b1, efsp_pkg::ADDR_CTRL, 32'h1);
        apb(1'b1, efsp_pkg::ADDR_FBCFG, 32'h0700);
        jog(4, 32'd140);
        apb(1'b1, efsp_pkg::ADDR_FBCFG, 32'h0);
        apb(1'b1, efsp_pkg::ADDR_PPR, 32'h04000010);
        check("ready early", 32'h0, 32'(driveReady));
        softwareEnable <= 1'b1;
        phase(efsp_pkg::RC_ENABLE);
        softwareEnable <= 1'b0;
        alarmCode <= 8'h05;
        phase(efsp_pkg::RC_NOTRDY);
        alarmCode <= 8'h00;
        inrushClosed <= 1'b0;
        phase(efsp_pkg::RC_NOTRDY);
        inrushClosed <= 1'b1;
        apb(1'b1, efsp_pkg::ADDR_RES, 32'h30c);
        phase(efsp_pkg::RC_POLES);
        apb(1'b1, efsp_pkg::ADDR_RES, 32'h40c);
        reverse <= 1'b1;
        phase(efsp_pkg::RC_SIGN);
        reverse <= 1'b0;
        phase(efsp_pkg::RC_OK);
        check("outcome", 32'h1, 32'(phasingOk));
        check("ready", 32'h1, 32'(driveReady));
        rdc("cmd bit", efsp_pkg::ADDR_CTRL, 32'h0, 32'h4);
        check("ref resets", 32'd6, refs);
        alarmCode <= 8'h03;
        repeat (3) @(posedge clk);
        check("ready alarm", 32'h0, 32'(driveReady));
        do_reset(2'h1);
        check("outcome reset", 32'h0, 32'(phasingOk));
        check("supply new", 32'h1, 32'(encSupplySel));
        stop_test();
    end
endmodule
